// *** flsp_ctrl.v ***
// Contract
// - Protect and unprotect only with high voltage on reset pin, normal cycles.
// - Host protects every sector before the first unprotect write.
// - Host re-protects each wanted sector separately after global unprotect.
// - Host always drives write guard pin to a defined level.
// - Host enters secured region with three-cycle sequence, leaves with exit sequence.
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.vh"

module flsp_ctrl #(
  parameter NBLK = `FLSP_NBLK,
  parameter [15:0] HV_CYC = `FLSP_HV_CYC,
  parameter [15:0] RST_CYC = `FLSP_RST_CYC
) (
  input wire clock,
  input wire resetn,
  input wire cmd_valid,
  input wire [3:0] cmd_op,
  input wire [19:0] cmd_addr,
  input wire [15:0] cmd_data,
  input wire [4:0] cmd_block,
  input wire [NBLK-1:0] keep_mask,
  input wire boot_top,
  input wire guard_high,
  output reg cmd_ready,
  output reg cmd_done,
  output reg [15:0] cmd_rdata,
  output reg verify_fail,
  output reg hv_on,
  output reg temp_mode,
  output reg in_secured,
  output wire [19:0] flash_addr,
  output wire [15:0] flash_dq_out,
  output wire flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output wire flash_ce_n,
  output wire flash_we_n,
  output wire flash_oe_n,
  output reg flash_reset_n,
  output reg flash_reset_hv,
  output reg write_guard_accel_pin
);
  localparam S_IDLE = 3'd0;
  localparam S_HV_UP = 3'd1;
  localparam S_ISSUE = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_HV_DOWN = 3'd4;
  localparam S_RST = 3'd5;
  localparam S_DONE = 3'd6;
  localparam [31:0] LAST_IDX = NBLK - 1;
  localparam [4:0] LAST_BLK = LAST_IDX[4:0];

  reg [2:0] state;
  reg [3:0] op;
  reg [1:0] phase;
  reg sub;
  reg [4:0] blk;
  reg [1:0] idx;
  reg [19:0] op_addr;
  reg [15:0] op_data;
  reg [15:0] wait_cnt;
  reg start;
  reg cur_we;
  reg [19:0] cur_addr;
  reg [15:0] cur_data;
  wire bus_done;
  wire [15:0] bus_rdata;
  wire [19:0] blk_addr;

  // Each block is addressed through its first sector; the device applies the
  // action to the whole block.
  function [7:0] blk_sector;
    input top;
    input [4:0] i;
    begin
      blk_sector = 8'h00;
      if (top)
      begin
        case (i)
          5'd0: blk_sector = 8'h00;
          5'd1: blk_sector = 8'h08;
          5'd2: blk_sector = 8'h20;
          5'd3: blk_sector = 8'h40;
          5'd4: blk_sector = 8'h60;
          5'd5: blk_sector = 8'h80;
          5'd6: blk_sector = 8'hA0;
          5'd7: blk_sector = 8'hC0;
          5'd8: blk_sector = 8'hE0;
          default: blk_sector = 8'hF8 + {3'b000, i - 5'd9};
        endcase
      end
      else
      begin
        case (i)
          5'd8: blk_sector = 8'h08;
          5'd9: blk_sector = 8'h20;
          5'd10: blk_sector = 8'h40;
          5'd11: blk_sector = 8'h60;
          5'd12: blk_sector = 8'h80;
          5'd13: blk_sector = 8'hA0;
          5'd14: blk_sector = 8'hC0;
          5'd15: blk_sector = 8'hE0;
          5'd16: blk_sector = 8'hF8;
          default: blk_sector = {3'b000, i};
        endcase
      end
    end
  endfunction

  assign blk_addr = {blk_sector(boot_top, blk), 12'h000};

  always @*
  begin
    cur_we = 1'b1;
    cur_addr = 20'h0_0000;
    cur_data = 16'h0000;
    case (op)
      `FLSP_OP_READ:
      begin
        cur_we = 1'b0;
        cur_addr = op_addr;
      end
      `FLSP_OP_WRITE:
      begin
        cur_addr = op_addr;
        cur_data = op_data;
      end
      `FLSP_OP_SEC_ENTER, `FLSP_OP_SEC_EXIT:
      begin
        cur_addr = (idx == 2'd0) ? `FLSP_UNLK1_ADDR :
                   (idx == 2'd1) ? `FLSP_UNLK2_ADDR : `FLSP_UNLK1_ADDR;
        cur_data = (idx == 2'd0) ? `FLSP_UNLK1_DATA :
                   (idx == 2'd1) ? `FLSP_UNLK2_DATA :
                   (op == `FLSP_OP_SEC_ENTER) ? `FLSP_SEC_ENTER_DATA : `FLSP_SEC_EXIT_DATA;
      end
      `FLSP_OP_PROTECT, `FLSP_OP_UNPROT_ALL:
      begin
        if (op == `FLSP_OP_UNPROT_ALL && phase == `FLSP_PH_CLEAR)
        begin
          cur_addr = `FLSP_UNPROT_OFS;
          cur_data = `FLSP_UNPROT_DATA;
        end
        else if (!sub)
        begin
          cur_addr = blk_addr;
          cur_data = `FLSP_PROT_DATA;
        end
        else
        begin
          cur_we = 1'b0;
          cur_addr = blk_addr | `FLSP_ID_PROT_OFS;
        end
      end
      default:
        cur_we = 1'b0;
    endcase
  end

  flsp_bus_cycle u_cycle (
    .clock(clock),
    .resetn(resetn),
    .start(start),
    .is_write(cur_we),
    .addr(cur_addr),
    .wdata(cur_data),
    .done(bus_done),
    .rdata(bus_rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n)
  );

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= S_IDLE;
      op <= `FLSP_OP_READ;
      phase <= `FLSP_PH_ALL;
      sub <= 1'b0;
      blk <= 5'd0;
      idx <= 2'd0;
      op_addr <= 20'h0_0000;
      op_data <= 16'h0000;
      wait_cnt <= 16'h0000;
      start <= 1'b0;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
      cmd_rdata <= 16'h0000;
      verify_fail <= 1'b0;
      hv_on <= 1'b0;
      temp_mode <= 1'b0;
      in_secured <= 1'b0;
      flash_reset_n <= 1'b1;
      flash_reset_hv <= 1'b0;
      write_guard_accel_pin <= 1'b0;
    end
    else
    begin
      // The guard pin follows the user level from reset on and is never released.
      write_guard_accel_pin <= guard_high;
      start <= 1'b0;
      cmd_done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            op_addr <= cmd_addr;
            op_data <= cmd_data;
            phase <= `FLSP_PH_ALL;
            sub <= 1'b0;
            idx <= 2'd0;
            blk <= (cmd_op == `FLSP_OP_PROTECT) ? cmd_block : 5'd0;
            verify_fail <= 1'b0;
            case (cmd_op)
              `FLSP_OP_PROTECT, `FLSP_OP_UNPROT_ALL, `FLSP_OP_TEMP_ENTER:
              begin
                if (cmd_op == `FLSP_OP_PROTECT && cmd_block > LAST_BLK)
                begin
                  verify_fail <= 1'b1;
                  state <= S_DONE;
                end
                else if (hv_on)
                  state <= (cmd_op == `FLSP_OP_TEMP_ENTER) ? S_DONE : S_ISSUE;
                else
                begin
                  flash_reset_hv <= 1'b1;
                  wait_cnt <= HV_CYC - 16'h0001;
                  state <= S_HV_UP;
                end
              end
              `FLSP_OP_TEMP_EXIT:
              begin
                temp_mode <= 1'b0;
                flash_reset_hv <= 1'b0;
                hv_on <= 1'b0;
                wait_cnt <= HV_CYC - 16'h0001;
                state <= S_HV_DOWN;
              end
              `FLSP_OP_HW_RESET:
              begin
                temp_mode <= 1'b0;
                flash_reset_hv <= 1'b0;
                hv_on <= 1'b0;
                flash_reset_n <= 1'b0;
                wait_cnt <= RST_CYC - 16'h0001;
                state <= S_RST;
              end
              default:
                state <= S_ISSUE;
            endcase
          end
        end
        S_HV_UP:
        begin
          if (wait_cnt == 16'h0000)
          begin
            hv_on <= 1'b1;
            if (op == `FLSP_OP_TEMP_ENTER)
            begin
              temp_mode <= 1'b1;
              state <= S_DONE;
            end
            else
              state <= S_ISSUE;
          end
          else
            wait_cnt <= wait_cnt - 16'h0001;
        end
        S_ISSUE:
        begin
          // Blocks that are not to stay protected are skipped in the re-protect pass.
          if (op == `FLSP_OP_UNPROT_ALL && phase == `FLSP_PH_KEEP && !keep_mask[blk])
          begin
            // A skipped last block must not drop the voltage that temporary mode relies on.
            if (blk == LAST_BLK)
              state <= temp_mode ? S_DONE : S_HV_DOWN;
            else
              blk <= blk + 5'd1;
            if (blk == LAST_BLK && !temp_mode)
            begin
              flash_reset_hv <= 1'b0;
              hv_on <= 1'b0;
              wait_cnt <= HV_CYC - 16'h0001;
            end
          end
          else
          begin
            start <= 1'b1;
            state <= S_WAIT;
          end
        end
        S_WAIT:
        begin
          if (bus_done)
          begin
            state <= S_ISSUE;
            case (op)
              `FLSP_OP_READ:
              begin
                cmd_rdata <= bus_rdata;
                state <= S_DONE;
              end
              `FLSP_OP_SEC_ENTER, `FLSP_OP_SEC_EXIT:
              begin
                if (idx == `FLSP_SEQ_LEN - 2'd1)
                begin
                  in_secured <= (op == `FLSP_OP_SEC_ENTER);
                  state <= S_DONE;
                end
                else
                  idx <= idx + 2'd1;
              end
              `FLSP_OP_PROTECT, `FLSP_OP_UNPROT_ALL:
              begin
                if (op == `FLSP_OP_UNPROT_ALL && phase == `FLSP_PH_CLEAR)
                begin
                  phase <= `FLSP_PH_KEEP;
                  blk <= 5'd0;
                end
                else if (!sub)
                  sub <= 1'b1;
                else
                begin
                  sub <= 1'b0;
                  if (!bus_rdata[0])
                    verify_fail <= 1'b1;
                  if (op == `FLSP_OP_PROTECT || (blk == LAST_BLK && phase == `FLSP_PH_KEEP))
                    state <= temp_mode ? S_DONE : S_HV_DOWN;
                  else if (blk == LAST_BLK)
                    phase <= `FLSP_PH_CLEAR;
                  else
                    blk <= blk + 5'd1;
                  if (!temp_mode && (op == `FLSP_OP_PROTECT ||
                      (blk == LAST_BLK && phase == `FLSP_PH_KEEP)))
                  begin
                    flash_reset_hv <= 1'b0;
                    hv_on <= 1'b0;
                    wait_cnt <= HV_CYC - 16'h0001;
                  end
                end
              end
              default:
                state <= S_DONE;
            endcase
          end
        end
        S_HV_DOWN:
        begin
          if (wait_cnt == 16'h0000)
            state <= S_DONE;
          else
            wait_cnt <= wait_cnt - 16'h0001;
        end
        S_RST:
        begin
          if (wait_cnt == 16'h0000)
          begin
            flash_reset_n <= 1'b1;
            in_secured <= 1'b0;
            state <= S_DONE;
          end
          else
            wait_cnt <= wait_cnt - 16'h0001;
        end
        S_DONE:
        begin
          cmd_done <= 1'b1;
          cmd_ready <= 1'b1;
          state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** flsp_map.vh ***
`ifndef FLSP_MAP_VH
`define FLSP_MAP_VH

// User command codes.
`define FLSP_OP_READ 4'h0
`define FLSP_OP_WRITE 4'h1
`define FLSP_OP_PROTECT 4'h2
`define FLSP_OP_UNPROT_ALL 4'h3
`define FLSP_OP_TEMP_ENTER 4'h4
`define FLSP_OP_TEMP_EXIT 4'h5
`define FLSP_OP_SEC_ENTER 4'h6
`define FLSP_OP_SEC_EXIT 4'h7
`define FLSP_OP_HW_RESET 4'h8

// Unprotect-all phases.
`define FLSP_PH_ALL 2'h0
`define FLSP_PH_CLEAR 2'h1
`define FLSP_PH_KEEP 2'h2

// Protection blocks per boot layout.
`define FLSP_NBLK 17

// Timing, in ns; the clock counts below are these times at 100 MHz, rounded up.
`define FLSP_T_SETUP_NS 10
`define FLSP_T_PULSE_NS 40
`define FLSP_T_HOLD_NS 20
`define FLSP_T_HV_SETTLE_NS 4000
`define FLSP_T_RST_PULSE_NS 500
`define FLSP_SETUP_CYC 16'h0001
`define FLSP_PULSE_CYC 16'h0004
`define FLSP_HOLD_CYC 16'h0002
`define FLSP_HV_CYC 16'h0190
`define FLSP_RST_CYC 16'h0032

// Bus-cycle words; set these to the part's command table.
`define FLSP_SEQ_LEN 2'h3
`define FLSP_UNLK1_ADDR 20'h0_0555
`define FLSP_UNLK1_DATA 16'h00AA
`define FLSP_UNLK2_ADDR 20'h0_02AA
`define FLSP_UNLK2_DATA 16'h0055
`define FLSP_SEC_ENTER_DATA 16'h0088
`define FLSP_SEC_EXIT_DATA 16'h0090
`define FLSP_PROT_DATA 16'h0060
`define FLSP_UNPROT_DATA 16'h0060
`define FLSP_UNPROT_OFS 20'h0_0040
`define FLSP_ID_PROT_OFS 20'h0_0002

`endif

// *** flsp_bus_cycle.v ***
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.vh"

module flsp_bus_cycle #(
  parameter [15:0] SETUP_CYC = `FLSP_SETUP_CYC,
  parameter [15:0] PULSE_CYC = `FLSP_PULSE_CYC,
  parameter [15:0] HOLD_CYC = `FLSP_HOLD_CYC
) (
  input wire clock,
  input wire resetn,
  input wire start,
  input wire is_write,
  input wire [19:0] addr,
  input wire [15:0] wdata,
  output reg done,
  output reg [15:0] rdata,
  output reg [19:0] flash_addr,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [15:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_we_n,
  output reg flash_oe_n
);
  localparam B_IDLE = 2'd0;
  localparam B_SETUP = 2'd1;
  localparam B_PULSE = 2'd2;
  localparam B_HOLD = 2'd3;

  reg [1:0] state;
  reg [15:0] cnt;
  reg wr;

  // Read data is sampled on the last cycle of the strobe, when it has settled longest.
  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= B_IDLE;
      cnt <= 16'h0000;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 20'h0_0000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        B_IDLE:
        begin
          if (start)
          begin
            wr <= is_write;
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= is_write;
            flash_ce_n <= 1'b0;
            cnt <= SETUP_CYC - 16'h0001;
            state <= B_SETUP;
          end
        end
        B_SETUP:
        begin
          if (cnt == 16'h0000)
          begin
            flash_we_n <= ~wr;
            flash_oe_n <= wr;
            cnt <= PULSE_CYC - 16'h0001;
            state <= B_PULSE;
          end
          else
            cnt <= cnt - 16'h0001;
        end
        B_PULSE:
        begin
          if (cnt == 16'h0000)
          begin
            if (!wr)
              rdata <= flash_dq_in;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt <= HOLD_CYC - 16'h0001;
            state <= B_HOLD;
          end
          else
            cnt <= cnt - 16'h0001;
        end
        B_HOLD:
        begin
          if (cnt == 16'h0000)
          begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            state <= B_IDLE;
          end
          else
            cnt <= cnt - 16'h0001;
        end
        default:
          state <= B_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** flsp_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.vh"

module flsp_ctrl_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic guard_high,
  input wire logic hv_on,
  input wire logic temp_mode,
  input wire logic in_secured,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  input wire logic flash_reset_hv,
  input wire logic write_guard_accel_pin
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  take_drop_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("request taken but ready stayed high");
  done_pulse_a: assert property (cmd_done |-> cmd_ready ##1 !cmd_done)
    else $error("done is not a one-cycle pulse with ready");
  we_pulse_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
    else $error("write strobe width wrong");
  write_qual_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
    else $error("write strobe without select or data drive");
  hv_gate_a: assert property (!flash_we_n && flash_dq_out == `FLSP_PROT_DATA |-> flash_reset_hv)
    else $error("protect word written without high voltage");
  temp_hv_a: assert property ($rose(temp_mode) |-> hv_on && flash_reset_hv && flash_reset_n)
    else $error("temporary mode without high voltage");
  hv_flag_a: assert property ($rose(hv_on) |-> flash_reset_hv && flash_reset_n)
    else $error("high voltage flag without high voltage drive");
  guard_drive_a: assert property ($changed(guard_high) |=> write_guard_accel_pin == $past(guard_high))
    else $error("guard pin does not follow request");
  secured_reset_a: assert property ($rose(flash_reset_n) |-> !in_secured)
    else $error("secured mapping survived hardware reset");

  temp_cov: cover property ($rose(temp_mode));
  secured_cov: cover property ($rose(in_secured));
  protect_cov: cover property (!flash_we_n && flash_reset_hv);
endmodule

bind flsp_ctrl flsp_ctrl_chk u_flsp_ctrl_chk (
  .clock, .resetn, .cmd_valid, .cmd_ready, .cmd_done, .guard_high, .hv_on, .temp_mode,
  .in_secured, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n,
  .flash_reset_n, .flash_reset_hv, .write_guard_accel_pin
);
`default_nettype wire

// *** flsp_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.vh"

module flsp_flash_model #(
  parameter bit FACTORY_LOCKED = 1'b0
) (
  input wire logic [19:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe,
  output logic [15:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  input wire logic flash_reset_hv,
  input wire logic write_guard_accel_pin,
  input wire logic boot_top
);
  // Protection is never touched by the reset pin, like the real cells.
  logic [16:0] prot = 17'h0_0000;
  logic [15:0] mem [int];
  logic [15:0] smem [int];
  logic secured = 1'b0;
  logic [1:0] unl = 2'h0;
  logic [15:0] last_rd = 16'h0000;

  function automatic int blk(input logic [7:0] s);
    if (boot_top)
      return (s < 8'h08) ? 0 : (s < 8'h20) ? 1 : (s < 8'hE0) ? 1 + s[7:5] : (s < 8'hF8) ? 8 : 9 + s[2:0];
    return (s < 8'h08) ? s[2:0] : (s < 8'h20) ? 8 : (s < 8'hE0) ? 8 + s[7:5] : (s < 8'hF8) ? 15 : 16;
  endfunction

  function automatic bit boot(input logic [19:0] a);
    return boot_top ? (a[19:15] == 5'h1F) : (a[19:15] == 5'h00);
  endfunction

  function automatic bit locked(input logic [19:0] a);
    logic outer;
    outer = boot_top ? (a[19:13] == 7'h7F) : (a[19:13] == 7'h00);
    return (!write_guard_accel_pin && outer) || (prot[blk(a[19:12])] && !flash_reset_hv);
  endfunction

  function automatic logic [15:0] rd_val(input logic [19:0] a);
    if (flash_reset_hv && a[11:0] == 12'h002)
      return {15'h0000, prot[blk(a[19:12])]};
    if (secured && boot(a))
      return smem.exists(a) ? smem[a] : 16'hFFFF;
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Released lines show the inverse of the last word, so a late sample cannot pass by luck.
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val(flash_addr) : ~last_rd;

  always @(posedge flash_oe_n)
    last_rd = rd_val(flash_addr);

  always @(negedge flash_reset_n)
  begin
    secured = 1'b0;
    unl = 2'h0;
  end

  task automatic write_word(input logic [19:0] a, input logic [15:0] d);
    logic [1:0] nu;
    nu = (a == `FLSP_UNLK1_ADDR && d == `FLSP_UNLK1_DATA) ? 2'h1 :
         (unl == 2'h1 && a == `FLSP_UNLK2_ADDR && d == `FLSP_UNLK2_DATA) ? 2'h2 : 2'h0;
    if (unl == 2'h2 && d == `FLSP_SEC_ENTER_DATA)
      secured = 1'b1;
    else if (unl == 2'h2 && d == `FLSP_SEC_EXIT_DATA)
      secured = 1'b0;
    else if (flash_reset_hv && d == `FLSP_PROT_DATA && a[11:0] == 12'h040)
      prot = 17'h0_0000;
    else if (flash_reset_hv && d == `FLSP_PROT_DATA)
      prot[blk(a[19:12])] = 1'b1;
    else if (nu == 2'h0 && secured && boot(a) && !FACTORY_LOCKED)
      smem[a] = (smem.exists(a) ? smem[a] : 16'hFFFF) & d;
    else if (nu == 2'h0 && !secured && !locked(a))
      mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
    unl = nu;
  endtask

  always @(posedge flash_we_n)
    if (!flash_ce_n && flash_oe_n && flash_dq_oe && flash_reset_n)
      write_word(flash_addr, flash_dq_out);
endmodule
`default_nettype wire

// *** flsp_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flsp_map.vh"

module flsp_ctrl_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [19:0] cmd_addr = 20'h0_0000;
  logic [15:0] cmd_data = 16'h0000;
  logic [4:0] cmd_block = 5'h00;
  logic [16:0] keep_mask = 17'h0_0000;
  logic boot_top = 1'b1;
  logic guard_high = 1'b1;
  wire cmd_ready, cmd_done, verify_fail, hv_on, temp_mode, in_secured;
  wire [15:0] cmd_rdata, flash_dq_out, flash_dq_in;
  wire [19:0] flash_addr;
  wire flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n, flash_reset_hv;
  wire write_guard_accel_pin;
  int err_total = 0;
  int n_compared = 0;

  always #5 clock = ~clock;

  flsp_ctrl #(.HV_CYC(16'h0004), .RST_CYC(16'h0004)) u_flsp_ctrl (
    .clock, .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_block, .keep_mask,
    .boot_top, .guard_high, .cmd_ready, .cmd_done, .cmd_rdata, .verify_fail, .hv_on,
    .temp_mode, .in_secured, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .flash_reset_hv,
    .write_guard_accel_pin
  );

  flsp_flash_model u_flsp_flash_model (
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_reset_n, .flash_reset_hv, .write_guard_accel_pin, .boot_top
  );

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Requests are raised on a rising edge and outputs are sampled on falling edges.
  task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d,
                     input logic [4:0] b);
    int n;
    n = 0;
    do
      @(negedge clock);
    while (cmd_ready !== 1'b1 && ++n < 2000);
    @(posedge clock);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_block <= b;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    do
      @(negedge clock);
    while (cmd_done !== 1'b1 && ++n < 20000);
    if (cmd_done !== 1'b1)
    begin
      err_total++;
      $display("[ERR] %0t command did not complete", $time);
      tally_and_finish();
    end
  endtask

  // Flash only clears bits, so the expected word after a program is old AND new.
  task automatic wr_rd(input logic [19:0] a, input bit ok);
    logic [15:0] old;
    logic [15:0] d;
    d = {2'b01, 14'($urandom)};
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    old = cmd_rdata;
    run(`FLSP_OP_WRITE, a, d, 5'h00);
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    check(cmd_rdata, ok ? (old & d) : old);
  endtask

  function automatic logic [19:0] blk_addr(input logic top, input int b, input logic [31:0] r);
    logic [7:0] s;
    if (top)
      s = (b == 0) ? 8'h00 : (b == 1) ? 8'h08 : (b < 8) ? {3'(b - 1), r[4:0]} :
          (b == 8) ? 8'hE0 : 8'(8'hF8 + b - 9);
    else
      s = (b < 8) ? 8'(b) : (b == 8) ? 8'h08 : (b < 15) ? {3'(b - 8), r[4:0]} :
          (b == 15) ? 8'hE0 : 8'hF8;
    return {s, 4'h1, r[15:8]};
  endfunction

  initial
  begin
    logic [19:0] a;
    logic [15:0] d0;
    int b;
    void'($urandom(32'hd4fb3b49));
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    for (int lay = 0; lay < 2; lay++)
    begin
      @(posedge clock);
      boot_top <= (lay == 0);
      b = (lay == 0) ? $urandom_range(7, 2) : $urandom_range(14, 9);
      a = blk_addr(lay == 0, b, $urandom);
      wr_rd(a, 1'b1);
      run(`FLSP_OP_PROTECT, 20'h0_0000, 16'h0000, 5'(b));
      check(16'(verify_fail), 16'h0000);
      wr_rd(blk_addr(boot_top, b, $urandom), 1'b0);
      run(`FLSP_OP_TEMP_ENTER, 20'h0_0000, 16'h0000, 5'h00);
      check(16'(temp_mode), 16'h0001);
      wr_rd(a, 1'b1);
      run(`FLSP_OP_TEMP_EXIT, 20'h0_0000, 16'h0000, 5'h00);
      wr_rd(a, 1'b0);
      @(posedge clock);
      keep_mask <= 17'($urandom);
      run(`FLSP_OP_UNPROT_ALL, 20'h0_0000, 16'h0000, 5'h00);
      check(16'(verify_fail), 16'h0000);
      for (int i = 0; i < 17; i++)
        wr_rd(blk_addr(boot_top, i, $urandom), !keep_mask[i]);
      @(posedge clock);
      keep_mask <= 17'h0_0000;
      run(`FLSP_OP_UNPROT_ALL, 20'h0_0000, 16'h0000, 5'h00);
      a = {boot_top ? 8'hFF : 8'h01, 4'h1, 8'($urandom)};
      @(posedge clock);
      guard_high <= 1'b0;
      repeat (2) @(posedge clock);
      wr_rd(a, 1'b0);
      run(`FLSP_OP_TEMP_ENTER, 20'h0_0000, 16'h0000, 5'h00);
      wr_rd(a, 1'b0);
      run(`FLSP_OP_TEMP_EXIT, 20'h0_0000, 16'h0000, 5'h00);
      @(posedge clock);
      guard_high <= 1'b1;
      repeat (2) @(posedge clock);
      wr_rd(a, 1'b1);
    end
    a = {8'h02, 4'h1, 8'($urandom)};
    wr_rd(a, 1'b1);
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    d0 = cmd_rdata;
    run(`FLSP_OP_SEC_ENTER, 20'h0_0000, 16'h0000, 5'h00);
    check(16'(in_secured), 16'h0001);
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    check(cmd_rdata, 16'hFFFF);
    wr_rd(a, 1'b1);
    run(`FLSP_OP_SEC_EXIT, 20'h0_0000, 16'h0000, 5'h00);
    check(16'(in_secured), 16'h0000);
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    check(cmd_rdata, d0);
    run(`FLSP_OP_SEC_ENTER, 20'h0_0000, 16'h0000, 5'h00);
    run(`FLSP_OP_HW_RESET, 20'h0_0000, 16'h0000, 5'h00);
    check(16'(in_secured), 16'h0000);
    run(`FLSP_OP_READ, a, 16'h0000, 5'h00);
    check(cmd_rdata, d0);
    run(`FLSP_OP_PROTECT, 20'h0_0000, 16'h0000, 5'h11);
    check(16'(verify_fail), 16'h0001);
    run(4'h9, a, 16'h0000, 5'h00);
    check(cmd_rdata, d0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
